//--- common/mcs_pkg.sv
// error pattern, cutoff, indicator timing and state encodings for the motor controller status block
// assumes a 100 MHz system clock; all times are turned into cycle counts here
package mcs_pkg;

  // ------------------------------------------------------------
  // clock and indicator timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned BLINK_HALF_MS   = 150;   // on or off time of one flash
  localparam int unsigned PAUSE_MS        = 1200;  // long dark gap after a flash group
  localparam int unsigned FLICKER_HALF_MS = 40;    // fast flicker half period
  localparam int unsigned ACT_DARK_MS     = 30;    // dark gap that marks activity
  localparam int unsigned BLINK_HALF_CYC   = BLINK_HALF_MS * CYC_PER_MS;
  localparam int unsigned PAUSE_CYC        = PAUSE_MS * CYC_PER_MS;
  localparam int unsigned FLICKER_HALF_CYC = FLICKER_HALF_MS * CYC_PER_MS;
  localparam int unsigned ACT_DARK_CYC     = ACT_DARK_MS * CYC_PER_MS;
  localparam logic [2:0]  LAMP_TEST_FLASHES = 3'h3;

  // ------------------------------------------------------------
  // undervoltage cutoff
  // ------------------------------------------------------------
  localparam logic [2:0]  LVC_OFF        = 3'h0;
  localparam logic [2:0]  LVC_LEAD_ACID  = 3'h1;
  localparam logic [15:0] CELL_CUTOFF_MV = 16'h0BB8;  // 3000 mV per cell

  // ------------------------------------------------------------
  // serial framing, fixed
  // ------------------------------------------------------------
  localparam logic [3:0] UART_DATA_BITS = 4'h8;
  localparam logic       UART_PARITY    = 1'h0;
  localparam logic [1:0] UART_STOP_BITS = 2'h1;

  // ------------------------------------------------------------
  // error pattern selector and top state
  // ------------------------------------------------------------
  localparam logic [2:0] PAT_NONE    = 3'h0;  // 1..4 are flash counts
  localparam logic [2:0] PAT_FLICKER = 3'h5;
  localparam logic [2:0] PAT_SOLID   = 3'h6;

  typedef enum logic [1:0] {
    ST_TEST = 2'b01,
    ST_RUN  = 2'b10
  } mcs_state_t;

endpackage

//--- hw/mcs_status_config.sv
// status indicators, mode decode, cutoff decode and encoder counters of a two-channel motor controller
// assumes all inputs synchronous to clk; fault and activity flags come from the power and input logic
`timescale 1ns/1ps
module mcs_status_config #(
  parameter int unsigned ENC_W            = 32,
  parameter int unsigned BLINK_HALF_CYC   = mcs_pkg::BLINK_HALF_CYC,
  parameter int unsigned PAUSE_CYC        = mcs_pkg::PAUSE_CYC,
  parameter int unsigned FLICKER_HALF_CYC = mcs_pkg::FLICKER_HALF_CYC,
  parameter int unsigned ACT_DARK_CYC     = mcs_pkg::ACT_DARK_CYC
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clkEn,
  input  wire logic             dipSel1,
  input  wire logic             dipSel2,
  input  wire logic             dipSel3,
  input  wire logic             cutoffSelBit0,
  input  wire logic             cutoffSelBit1,
  input  wire logic             cutoffSelBit2,
  input  wire logic [2:0]       pktAddrSw,
  input  wire logic [2:0]       baudSw,
  input  wire logic             slaveSelEn,
  input  wire logic             ctrlInputA,
  input  wire logic             ctrlInputB,
  input  wire logic             ctrlInputC,
  input  wire logic             rcPulseSeen,
  input  wire logic             serialRxBusy,
  input  wire logic [1:0]       motorActive,
  input  wire logic [1:0]       overCurrent,
  input  wire logic             overTemp,
  input  wire logic             mainBattLow,
  input  wire logic             mainBattHigh,
  input  wire logic             logicBattLow,
  input  wire logic             logicBattHigh,
  input  wire logic [1:0]       encA,
  input  wire logic [1:0]       encB,
  output logic                  indicatorActivity,
  output logic                  indicatorMotorOn,
  output logic                  indicatorFault,
  output logic                  modeServo,
  output logic                  modeAnalog,
  output logic                  modeSimpleSerial,
  output logic                  modePacketSerial,
  output logic                  lvcMonitorEn,
  output logic                  lvcLeadAcidAuto,
  output logic [2:0]            lvcCellCount,
  output logic [15:0]           lvcCutoffMv,
  output logic                  estopActive,
  output logic                  flipActive,
  output logic                  cmdA,
  output logic                  cmdB,
  output logic                  cmdEnable,
  output logic                  serialTxEn,
  output logic [2:0]            busAddr,
  output logic [2:0]            baudSel,
  output logic [ENC_W-1:0]      encCount0,
  output logic [ENC_W-1:0]      encCount1
);

  // ------------------------------------------------------------
  // mode and option decode
  // ------------------------------------------------------------
  logic       servoNow;
  logic       analogNow;
  logic       simpleNow;
  logic       packetNow;
  logic [2:0] cutCode;

  // switch three on without switch one falls to packet serial
  assign servoNow  = dipSel1;
  assign analogNow = !dipSel1 && !dipSel2 && !dipSel3;
  assign simpleNow = !dipSel1 && dipSel2 && !dipSel3;
  assign packetNow = !dipSel1 && dipSel3;
  assign cutCode   = {cutoffSelBit2, cutoffSelBit1, cutoffSelBit0};

  // ------------------------------------------------------------
  // indicator sequencing
  // ------------------------------------------------------------
  mcs_pkg::mcs_state_t state;
  mcs_pkg::mcs_state_t next_state;
  logic [31:0] timer;
  logic [31:0] next_timer;
  logic [3:0]  stepIdx;
  logic [3:0]  next_stepIdx;
  logic [2:0]  patSel;
  logic [2:0]  next_patSel;
  logic [31:0] actCnt;
  logic [31:0] next_actCnt;
  logic        next_indActivity;
  logic        next_indMotorOn;
  logic        next_indFault;

  // pattern engine: steps 0..2n-1 alternate lit/dark, step 2n is the long pause
  always_comb begin
    logic [2:0]  selNow;
    logic [3:0]  lastStep;
    logic [31:0] limit;
    logic        lit;
    selNow           = mcs_pkg::PAT_NONE;
    lastStep         = 4'h0;
    limit            = 32'(BLINK_HALF_CYC);
    lit              = 1'b0;
    next_state       = state;
    next_timer       = timer + 32'h1;
    next_stepIdx     = stepIdx;
    next_patSel      = patSel;
    next_actCnt      = actCnt;
    next_indActivity = 1'b1;
    next_indMotorOn  = |motorActive;
    next_indFault    = 1'b0;
    // fixed priority, overcurrent first
    if (|overCurrent) begin
      selNow = mcs_pkg::PAT_SOLID;
    end else if (overTemp) begin
      selNow = 3'h1;
    end else if (mainBattLow) begin
      selNow = 3'h2;
    end else if (mainBattHigh) begin
      selNow = mcs_pkg::PAT_FLICKER;
    end else if (logicBattLow) begin
      selNow = 3'h3;
    end else if (logicBattHigh) begin
      selNow = 3'h4;
    end
    if (state == mcs_pkg::ST_TEST) begin
      selNow = mcs_pkg::LAMP_TEST_FLASHES;
    end
    // a new fault restarts its pattern from the first flash
    if (state == mcs_pkg::ST_RUN && selNow != patSel) begin
      next_patSel  = selNow;
      next_timer   = 32'h0;
      next_stepIdx = 4'h0;
    end else begin
      if (patSel == mcs_pkg::PAT_FLICKER) begin
        limit    = 32'(FLICKER_HALF_CYC);
        lastStep = 4'h1;
      end else begin
        lastStep = {patSel, 1'b0};
        if (stepIdx == lastStep) begin
          limit = 32'(PAUSE_CYC);
        end
      end
      if (timer >= limit - 32'h1) begin
        next_timer = 32'h0;
        if (state == mcs_pkg::ST_TEST && stepIdx == lastStep - 4'h1) begin
          next_state   = mcs_pkg::ST_RUN;
          next_stepIdx = 4'h0;
          next_patSel  = mcs_pkg::PAT_NONE;
        end else if (stepIdx == lastStep) begin
          next_stepIdx = 4'h0;
        end else begin
          next_stepIdx = stepIdx + 4'h1;
        end
      end
    end
    lit = ({1'b0, next_stepIdx} < {next_patSel, 1'b0}) && !next_stepIdx[0];
    // activity: a retriggered dark gap marks each pulse or received byte
    if ((servoNow && rcPulseSeen) || ((simpleNow || packetNow) && serialRxBusy)) begin
      next_actCnt = 32'(ACT_DARK_CYC);
    end else if (actCnt != 32'h0) begin
      next_actCnt = actCnt - 32'h1;
    end
    if (analogNow) begin
      next_indActivity = 1'b1;
    end else begin
      next_indActivity = (next_actCnt == 32'h0);
    end
    // fault indicator by pattern
    if (next_patSel == mcs_pkg::PAT_SOLID) begin
      next_indFault    = 1'b1;
      next_indActivity = overCurrent[0];
      next_indMotorOn  = overCurrent[1];
    end else if (next_patSel == mcs_pkg::PAT_FLICKER) begin
      next_indFault = !next_stepIdx[0];
    end else begin
      next_indFault = lit;
    end
    if (next_state == mcs_pkg::ST_TEST) begin
      next_indActivity = lit;
      next_indMotorOn  = lit;
      next_indFault    = lit;
    end
  end

  // indicator registers; clkEn low freezes everything
  always_ff @(posedge clk) begin
    if (rst) begin
      state             <= mcs_pkg::ST_TEST;
      timer             <= 32'h0;
      stepIdx           <= 4'h0;
      patSel            <= mcs_pkg::LAMP_TEST_FLASHES;
      actCnt            <= 32'h0;
      indicatorActivity <= 1'b0;
      indicatorMotorOn  <= 1'b0;
      indicatorFault    <= 1'b0;
    end else if (clkEn) begin
      state             <= next_state;
      timer             <= next_timer;
      stepIdx           <= next_stepIdx;
      patSel            <= next_patSel;
      actCnt            <= next_actCnt;
      indicatorActivity <= next_indActivity;
      indicatorMotorOn  <= next_indMotorOn;
      indicatorFault    <= next_indFault;
    end
  end

  // ------------------------------------------------------------
  // configuration and control input roles
  // ------------------------------------------------------------
  logic [20:0] next_cfg;

  // estop is active low; the pull-up lives in the pad so an open pin reads high
  always_comb begin
    next_cfg = {servoNow, analogNow, simpleNow, packetNow,
                cutCode != mcs_pkg::LVC_OFF,
                cutCode == mcs_pkg::LVC_LEAD_ACID,
                (cutCode > mcs_pkg::LVC_LEAD_ACID) ? cutCode : 3'h0,
                (simpleNow || packetNow) && !ctrlInputC,
                (servoNow || analogNow) && !ctrlInputC,
                ctrlInputA, ctrlInputB,
                !(simpleNow && slaveSelEn) || ctrlInputB,
                packetNow,
                pktAddrSw,
                baudSw};
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      {modeServo, modeAnalog, modeSimpleSerial, modePacketSerial, lvcMonitorEn, lvcLeadAcidAuto,
       lvcCellCount, estopActive, flipActive, cmdA, cmdB, cmdEnable, serialTxEn, busAddr,
       baudSel} <= 21'h0;
      lvcCutoffMv <= 16'h0;
    end else if (clkEn) begin
      {modeServo, modeAnalog, modeSimpleSerial, modePacketSerial, lvcMonitorEn, lvcLeadAcidAuto,
       lvcCellCount, estopActive, flipActive, cmdA, cmdB, cmdEnable, serialTxEn, busAddr,
       baudSel} <= next_cfg;
      lvcCutoffMv <= 16'(next_cfg[14:12] * mcs_pkg::CELL_CUTOFF_MV);  // cell count field
    end
  end

  // ------------------------------------------------------------
  // quadrature counters, x4 decode
  // ------------------------------------------------------------
  logic [1:0]       encPrev [2];
  logic [ENC_W-1:0] encCnt  [2];

  for (genvar ch = 0; ch < 2; ch++) begin : gEnc
    logic [1:0]       next_prev;
    logic [ENC_W-1:0] next_cnt;
    // one edge per step; a double change is a glitch and is dropped
    always_comb begin
      next_prev = {encA[ch], encB[ch]};
      next_cnt  = encCnt[ch];
      if (packetNow && ((encA[ch] ^ encPrev[ch][1]) ^ (encB[ch] ^ encPrev[ch][0]))) begin
        if (encA[ch] ^ encPrev[ch][0]) begin
          next_cnt = encCnt[ch] + 1'b1;
        end else begin
          next_cnt = encCnt[ch] - 1'b1;
        end
      end
    end
    always_ff @(posedge clk) begin
      if (rst) begin
        encPrev[ch] <= 2'h0;
        encCnt[ch]  <= '0;
      end else if (clkEn) begin
        encPrev[ch] <= next_prev;
        encCnt[ch]  <= next_cnt;
      end
    end
  end

  assign encCount0 = encCnt[0];
  assign encCount1 = encCnt[1];

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  lamp_test_a: assert property (state == mcs_pkg::ST_TEST |->
    indicatorActivity == indicatorFault && indicatorMotorOn == indicatorFault)
    else $error("lamp test indicators differ");
  analog_leds_a: assert property (clkEn && state == mcs_pkg::ST_RUN && analogNow && overCurrent == 2'h0 |=>
    indicatorActivity && indicatorMotorOn == $past(|motorActive))
    else $error("analog indicators wrong");
  rc_blink_a: assert property (clkEn && state == mcs_pkg::ST_RUN && servoNow && rcPulseSeen
    && overCurrent == 2'h0 |=> !indicatorActivity)
    else $error("no dark gap on pulse");
  serial_blink_a: assert property (clkEn && state == mcs_pkg::ST_RUN && simpleNow && serialRxBusy
    && overCurrent == 2'h0 |=> !indicatorActivity)
    else $error("no dark gap on receive");
  oc_solid_a: assert property (clkEn && state == mcs_pkg::ST_RUN && |overCurrent |=>
    indicatorFault && indicatorActivity == $past(overCurrent[0]) && indicatorMotorOn == $past(overCurrent[1]))
    else $error("overcurrent display wrong");
  err_pause_a: assert property (state == mcs_pkg::ST_RUN && patSel >= 3'h1 && patSel <= 3'h4
    && stepIdx == {patSel, 1'b0} |-> !indicatorFault)
    else $error("fault lit during pause");
  estop_a: assert property (clkEn && (simpleNow || packetNow) && !ctrlInputC |=> estopActive)
    else $error("estop not raised");
  lvc_cells_a: assert property (clkEn && cutCode >= 3'h2 |=>
    lvcMonitorEn && !lvcLeadAcidAuto && lvcCellCount == $past(cutCode)
    && lvcCutoffMv == 16'($past(cutCode)) * mcs_pkg::CELL_CUTOFF_MV)
    else $error("cutoff decode wrong");
  tx_dir_a: assert property (clkEn && simpleNow |=> !serialTxEn)
    else $error("transmit in simple serial");
  slave_sel_a: assert property (clkEn && simpleNow && slaveSelEn && !ctrlInputB |=> !cmdEnable)
    else $error("deselected unit enabled");
  quad_up_a: assert property (clkEn && packetNow && encPrev[0] == 2'h0 && encA[0] && !encB[0] |=>
    encCount0 == $past(encCount0) + 1'b1)
    else $error("encoder did not count up");
  enc_hold_a: assert property (clkEn && !packetNow |=> $stable(encCount0) && $stable(encCount1))
    else $error("encoder counted outside packet mode");

  lamp_done_c: cover property (state == mcs_pkg::ST_TEST ##1 state == mcs_pkg::ST_RUN);
  heat_pause_c: cover property (patSel == 3'h1 && stepIdx == 4'h2);
  flicker_c: cover property (patSel == mcs_pkg::PAT_FLICKER && indicatorFault ##1 !indicatorFault);
  quad_down_c: cover property (clkEn && packetNow && encPrev[1] == 2'h0 && encB[1] && !encA[1]);

endmodule

//--- test/mcs_host_model.sv
// far-side model: quadrature encoders on both channels and the stop line
// assumes the bench asks for steps just after the falling edge of clk
`timescale 1ns/1ps
module mcs_host_model (
  input  wire logic       clk,
  input  wire logic [1:0] stepUp,
  input  wire logic [1:0] stepDn,
  input  wire logic       estopReq,
  output logic      [1:0] encA,
  output logic      [1:0] encB,
  output logic            ctrlInputC
);
  logic [1:0] phase [2];

  // ----------------------------------------
  // encoder phase walk
  // ----------------------------------------
  initial begin
    phase[0] = 2'h0;
    phase[1] = 2'h0;
  end
  // one step per cycle at most, settled well before the rising edge
  always @(negedge clk) begin
    #1;
    for (int k = 0; k < 2; k++) begin
      if (stepUp[k]) phase[k] = phase[k] + 2'h1;
      else if (stepDn[k]) phase[k] = phase[k] - 2'h1;
    end
  end
  // a forward step lets A lead: 00, 10, 11, 01
  always_comb begin
    for (int k = 0; k < 2; k++) begin
      encA[k] = phase[k][0] ^ phase[k][1];
      encB[k] = phase[k][1];
    end
  end
  // line is pulled up unless the host pulls it low on purpose
  assign ctrlInputC = estopReq ? 1'b0 : 1'b1;
endmodule

//--- test/mcs_status_config_tb.sv
// bench for the status and configuration block, short timing parameters
// assumes the far-side model drives encoders and the stop line
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fails++; $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module mcs_status_config_tb;
  localparam int BH = 4;
  localparam int PA = 12;
  localparam int FH = 2;
  logic        clk, rst, clkEn, d1, d2, d3, c0, c1, c2, slEn, inA, inB, inC, rcP, rxB, estReq;
  logic        oT, mL, mH, lL, lH, ind1, ind2, indF, mSv, mAn, mSs, mPs, lEn, lLa, es, fl, cA, cB, cEn, tx;
  logic [1:0]  mAct, oc, stUp, stDn, encA, encB, eStop;
  logic [2:0]  addr, baud, lCells, bAddr, bSel, code, eCmd;
  logic [3:0]  eMode;
  logic [4:0]  eLvc;
  logic [6:0]  eSer;
  logic [15:0] lMv, eMv;
  logic [31:0] enc0, enc1;
  logic        prevF;
  int          fails, checked, i, k, n, lit, rises;
  int          cnt [2];

  mcs_status_config #(.BLINK_HALF_CYC(BH), .PAUSE_CYC(PA), .FLICKER_HALF_CYC(FH), .ACT_DARK_CYC(3)) dut (
    .clk(clk), .rst(rst), .clkEn(clkEn), .dipSel1(d1), .dipSel2(d2), .dipSel3(d3),
    .cutoffSelBit0(c0), .cutoffSelBit1(c1), .cutoffSelBit2(c2), .pktAddrSw(addr), .baudSw(baud),
    .slaveSelEn(slEn), .ctrlInputA(inA), .ctrlInputB(inB), .ctrlInputC(inC), .rcPulseSeen(rcP),
    .serialRxBusy(rxB), .motorActive(mAct), .overCurrent(oc), .overTemp(oT), .mainBattLow(mL),
    .mainBattHigh(mH), .logicBattLow(lL), .logicBattHigh(lH), .encA(encA), .encB(encB),
    .indicatorActivity(ind1), .indicatorMotorOn(ind2), .indicatorFault(indF), .modeServo(mSv),
    .modeAnalog(mAn), .modeSimpleSerial(mSs), .modePacketSerial(mPs), .lvcMonitorEn(lEn),
    .lvcLeadAcidAuto(lLa), .lvcCellCount(lCells), .lvcCutoffMv(lMv), .estopActive(es), .flipActive(fl),
    .cmdA(cA), .cmdB(cB), .cmdEnable(cEn), .serialTxEn(tx), .busAddr(bAddr), .baudSel(bSel),
    .encCount0(enc0), .encCount1(enc1));

  mcs_host_model host (.clk(clk), .stepUp(stUp), .stepDn(stDn), .estopReq(estReq), .encA(encA),
    .encB(encB), .ctrlInputC(inC));

  // ----------------------------------------
  // clock, watchdog, verdict
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // whole run is near 930 cycles, so 20000 means a hang
  initial begin
    #200000;
    fails++;
    $display("[ERR] %0t watchdog expired", $time);
    end_sim();
  end

  // ----------------------------------------
  // scenario tasks
  // ----------------------------------------
  // one trigger pulse, then count dark samples of the activity lamp
  task automatic act(input logic [2:0] md, input logic rx, input int dk);
    begin
      {d1, d2, d3} = md;
      repeat (4) @(negedge clk);
      if (rx) rxB = 1'b1;
      else rcP = 1'b1;
      @(negedge clk);
      rxB = 1'b0;
      rcP = 1'b0;
      // the first dark cycle is already showing at this edge
      n = (ind1 === 1'b0);
      repeat (8) begin @(negedge clk); n += (ind1 === 1'b0); end
      `CHK(n, dk)
    end
  endtask
  // window of two flash periods or four flicker periods: lit count and rising edges do not depend on phase
  task automatic fpat(input int fn);
    int w;
    begin
      w = fn ? 2 * (2 * BH * fn + PA) : 8 * FH;
      repeat (3) @(negedge clk);
      lit = 0;
      rises = 0;
      prevF = indF;
      repeat (w) begin
        @(negedge clk);
        lit += (indF === 1'b1);
        rises += (indF === 1'b1 && prevF === 1'b0);
        prevF = indF;
      end
      `CHK(lit, fn ? 2 * BH * fn : 4 * FH)
      `CHK(rises, fn ? 2 * fn : 4)
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    rst = 1'b1; clkEn = 1'b1; {d1, d2, d3, c0, c1, c2, slEn, inA, inB, rcP, rxB, estReq} = 12'h000;
    {oT, mL, mH, lL, lH} = 5'h00; mAct = 2'h0; oc = 2'h0; stUp = 2'h0; stDn = 2'h0;
    addr = 3'h0; baud = 3'h0; cnt[0] = 0; cnt[1] = 0; fails = 0; checked = 0;
    n = $urandom(59);
    repeat (4) @(negedge clk);
    `CHK({ind1, ind2, indF, mSv, mAn, mSs, mPs, tx}, 8'h00)
    rst = 1'b0;
    // lamp test: three lit/dark pairs; the first step began in reset, so it shows one cycle short
    // last sample is the first run cycle, analog mode with no fault
    for (k = 0; k < 6 * BH; k++) begin
      @(negedge clk);
      `CHK({ind1, ind2, indF}, (k == 6 * BH - 1) ? 3'h4 : (((k + 1) / BH) % 2 == 0) ? 3'h7 : 3'h0)
    end
    act(3'h4, 1'b0, 3);
    act(3'h2, 1'b1, 3);
    act(3'h1, 1'b1, 3);
    act(3'h0, 1'b0, 0);
    mAct = 2'h2;
    repeat (3) @(negedge clk);
    `CHK(ind2, 1'b1)
    mAct = 2'h0;
    repeat (3) @(negedge clk);
    `CHK(ind2, 1'b0)
    // each fault with all lower ones present shows only its own pattern
    for (i = 0; i < 5; i++) begin
      {oT, mL, mH, lL, lH} = 5'h1F >> i;
      fpat(i == 0 ? 1 : i == 1 ? 2 : i == 2 ? 0 : i == 3 ? 3 : 4);
    end
    {oT, mL, mH, lL, lH} = 5'h1F;
    oc = 2'h1;
    repeat (3) @(negedge clk);
    `CHK({indF, ind1, ind2}, 3'h6)
    oc = 2'h2;
    repeat (3) @(negedge clk);
    `CHK({indF, ind1, ind2}, 3'h5)
    oc = 2'h0;
    {oT, mL, mH, lL, lH} = 5'h04;
    repeat (3) @(negedge clk);
    {oT, mL, mH, lL, lH} = 5'h00;
    repeat (3) @(negedge clk);
    `CHK(indF, 1'b0)
    // random switches and inputs, clkEn low now and then must freeze outputs
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if (i > 0) begin
        `CHK({mSv, mAn, mSs, mPs}, eMode)
        `CHK({lEn, lLa, lCells}, eLvc)
        `CHK(lMv, eMv)
        `CHK({es, fl}, eStop)
        `CHK({cA, cB, cEn}, eCmd)
        `CHK({tx, bAddr, bSel}, eSer)
      end
      {d1, d2, d3, c2, c1, c0, slEn, inA, inB, estReq} = 10'($urandom);
      // first pass always updates so the expectations are defined before the first compare
      clkEn = (i == 0) || ($urandom % 4 != 0);
      addr = 3'($urandom);
      baud = 3'($urandom);
      if (clkEn) begin
        eMode = {d1, !d1 && !d2 && !d3, !d1 && d2 && !d3, !d1 && d3};
        code = {c2, c1, c0};
        eLvc = {code != 3'h0, code == 3'h1, code >= 3'h2 ? code : 3'h0};
        eMv = eLvc[2:0] * 16'h0BB8;
        eStop = {(eMode[1] || eMode[0]) && estReq, (eMode[3] || eMode[2]) && estReq};
        eCmd = {inA, inB, !(eMode[1] && slEn) || inB};
        eSer = {eMode[0], addr, baud};
      end
    end
    clkEn = 1'b1;
    // encoders count in packet serial, then hold in servo mode
    {d1, d2, d3} = 3'h1;
    repeat (3) @(negedge clk);
    for (i = 0; i < 240; i++) begin
      @(negedge clk);
      if (i == 160) {d1, d2, d3} = 3'h4;
      `CHK(enc0, 32'(cnt[0]))
      `CHK(enc1, 32'(cnt[1]))
      for (k = 0; k < 2; k++) begin
        n = (i % 80 > 3) ? $urandom % 3 : 0;
        stUp[k] = (n == 1);
        stDn[k] = (n == 2);
        if (i < 160 && n != 0) cnt[k] += (n == 1) ? 1 : -1;
      end
    end
    end_sim();
  end
endmodule
